/* File: hdl/frame_shift_move_defines.vh */
// Register map, field positions and decode patterns of the execute block
`ifndef FRAME_SHIFT_MOVE_DEFINES_VH
`define FRAME_SHIFT_MOVE_DEFINES_VH
`define OFS_OPCODE 8'h00
`define OFS_EXT_HI 8'h04
`define OFS_EXT_LO 8'h08
`define OFS_OPERAND 8'h0C
`define OFS_COUNT_REG 8'h10
`define OFS_STACK_PTR 8'h14
`define OFS_ADDR_REG_N 8'h18
`define OFS_CCR 8'h1C
`define OFS_CTRL 8'h20
`define OFS_STATUS 8'h24
`define OFS_RESULT 8'h28
`define OFS_PUSH_ADDR 8'h2C
`define OFS_PUSH_DATA 8'h30
`define CTRL_START_BIT 0
`define ST_BUSY_BIT 0
`define ST_DONE_BIT 1
`define ST_ILLEGAL_BIT 2
`define CCR_C 0
`define CCR_V 1
`define CCR_Z 2
`define CCR_N 3
`define CCR_X 4
`define CCR_RESET 5'h00
`define LINK_WORD_PAT 13'h09CA
`define LINK_LONG_PAT 13'h0901
`define SHIFT_MEM_PAT 7'h71
`define STACK_STEP 32'h00000004
`define SHIFT_MOD_MASK 6'h3F
`define KIND_NONE 3'h0
`define KIND_LINK 3'h1
`define KIND_SHIFT_REG 3'h2
`define KIND_SHIFT_MEM 3'h3
`define KIND_MOVE 3'h4
`endif

/* File: hdl/frame_shift_move_exec.v */
// Execute block for frame link, logical shift and data move, APB register access
// Notes on behaviour
// - Link: push register, copy pointer, add displacement
// - Word link displacement is sign-extended extension
// - Long link displacement: high word first
// - Link register in low bits; two opcode patterns
// - Left shift: msb out to C, X; zero in
// - Right shift: lsb out to C, X; zero in
// - Immediate count 1-7, zero means eight
// - Register count taken modulo 64
// - Memory shift: one bit, word size
// - X gets last bit out; zero count keeps
// - C last bit or clear; V clear; N, Z
// - Bit 8: 0 right, 1 left
// - Shift size 00 byte, 01 word, 10 long
// - Bit 5 picks immediate or register count
// - Memory shift accepts memory alterable modes only
// - Move copies, sets N Z, clears V C
// - Move size 01 byte, 11 word, 10 long
// - Move destination must be data alterable
// - Byte move rejects address register source
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "frame_shift_move_defines.vh"
module frame_shift_move_exec (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr
);
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_EXEC = 5'b00010;
  localparam [4:0] S_PUSH = 5'b00100;
  localparam [4:0] S_COPY = 5'b01000;
  localparam [4:0] S_ADD = 5'b10000;

  reg [4:0] state_r;
  reg [15:0] opcode_r;
  reg [15:0] ext_hi_r;
  reg [15:0] ext_lo_r;
  reg [31:0] operand_r;
  reg [31:0] count_reg_r;
  reg [31:0] stack_ptr_r;
  reg [31:0] addr_reg_n_r;
  reg [4:0] ccr_r;
  reg done_r;
  reg illegal_r;
  reg [2:0] kind_r;
  reg [31:0] result_r;
  reg [31:0] push_addr_r;
  reg [31:0] push_data_r;

  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire [7:0] ofs = paddr[7:0];
  wire busy = ~state_r[0];
  wire mapped = (paddr[31:8] == 24'h000000) && (ofs[1:0] == 2'b00) && (ofs <= `OFS_PUSH_DATA);
  // Unmapped or busy writes are dropped
  wire reg_wr = wr && !busy && mapped;

  // Decode
  wire is_link_w = (opcode_r[15:3] == `LINK_WORD_PAT);
  wire is_link_l = (opcode_r[15:3] == `LINK_LONG_PAT);
  wire [2:0] link_reg = opcode_r[2:0];
  wire is_shift_reg = (opcode_r[15:12] == 4'hE) && (opcode_r[4:3] == 2'b01)
    && (opcode_r[7:6] != 2'b11);
  wire is_shift_mem = (opcode_r[15:9] == `SHIFT_MEM_PAT) && (opcode_r[7:6] == 2'b11);
  wire [2:0] ea_mode = opcode_r[5:3];
  wire [2:0] ea_reg = opcode_r[2:0];
  wire mem_alt_ok = ((ea_mode >= 3'h2) && (ea_mode <= 3'h6))
    || ((ea_mode == 3'h7) && (ea_reg[2:1] == 2'b00));
  wire is_move = (opcode_r[15:14] == 2'b00) && (opcode_r[13:12] != 2'b00);
  wire [1:0] mv_size = opcode_r[13:12];
  wire [2:0] dst_reg = opcode_r[11:9];
  wire [2:0] dst_mode = opcode_r[8:6];
  wire [2:0] src_mode = opcode_r[5:3];
  wire [2:0] src_reg = opcode_r[2:0];
  wire dst_ok = (dst_mode != 3'h1)
    && ((dst_mode != 3'h7) || (dst_reg[2:1] == 2'b00));
  wire src_ok = ((src_mode != 3'h7) || (src_reg <= 3'h4))
    && !((mv_size == 2'b01) && (src_mode == 3'h1));

  // Link displacement
  wire [31:0] link_disp = is_link_l ? {ext_hi_r, ext_lo_r}
    : {{16{ext_hi_r[15]}}, ext_hi_r};

  // Shift parameters
  wire shift_left = opcode_r[8];
  reg [1:0] sh_size;
  reg [6:0] sh_count;
  always @* begin
    if (is_shift_mem) begin
      sh_size = 2'b01;
      sh_count = 7'h01;
    end else begin
      sh_size = opcode_r[7:6];
      if (opcode_r[5]) begin
        sh_count = {1'b0, count_reg_r[5:0] & `SHIFT_MOD_MASK};
      end else begin
        sh_count = (opcode_r[11:9] == 3'h0) ? 7'h08 : {4'h0, opcode_r[11:9]};
      end
    end
  end

  // Width mask and sign position for a size code
  function [31:0] size_mask;
    input [1:0] sz;
    begin
      case (sz)
        2'b00: size_mask = 32'h000000FF;
        2'b01: size_mask = 32'h0000FFFF;
        default: size_mask = 32'hFFFFFFFF;
      endcase
    end
  endfunction

  function [4:0] size_msb;
    input [1:0] sz;
    begin
      case (sz)
        2'b00: size_msb = 5'h07;
        2'b01: size_msb = 5'h0F;
        default: size_msb = 5'h1F;
      endcase
    end
  endfunction

  // Shifter
  reg [31:0] sh_val;
  reg sh_last;
  integer i;
  always @* begin
    sh_val = operand_r & size_mask(sh_size);
    sh_last = 1'b0;
    for (i = 0; i < 64; i = i + 1) begin
      if (i < sh_count) begin
        if (shift_left) begin
          sh_last = sh_val[size_msb(sh_size)];
          sh_val = (sh_val << 1) & size_mask(sh_size);
        end else begin
          sh_last = sh_val[0];
          sh_val = sh_val >> 1;
        end
      end
    end
  end
  wire [31:0] sh_merged = (operand_r & ~size_mask(sh_size)) | sh_val;
  wire sh_neg = sh_val[size_msb(sh_size)];

  // Move data
  reg [1:0] mv_sz_code;
  always @* begin
    case (mv_size)
      2'b01: mv_sz_code = 2'b00;
      2'b11: mv_sz_code = 2'b01;
      default: mv_sz_code = 2'b10;
    endcase
  end
  wire [31:0] mv_val = operand_r & size_mask(mv_sz_code);
  wire mv_neg = mv_val[size_msb(mv_sz_code)];

  // Status word
  reg [31:0] status_word;
  always @* begin
    status_word = 32'h00000000;
    status_word[`ST_BUSY_BIT] = busy;
    status_word[`ST_DONE_BIT] = done_r;
    status_word[`ST_ILLEGAL_BIT] = illegal_r;
    status_word[5:3] = kind_r;
  end

  // Main sequencer and registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      opcode_r <= 16'h0000;
      ext_hi_r <= 16'h0000;
      ext_lo_r <= 16'h0000;
      operand_r <= 32'h00000000;
      count_reg_r <= 32'h00000000;
      stack_ptr_r <= 32'h00000000;
      addr_reg_n_r <= 32'h00000000;
      ccr_r <= `CCR_RESET;
      done_r <= 1'b0;
      illegal_r <= 1'b0;
      kind_r <= `KIND_NONE;
      result_r <= 32'h00000000;
      push_addr_r <= 32'h00000000;
      push_data_r <= 32'h00000000;
    end else begin
      if (reg_wr) begin
        case (ofs)
          `OFS_OPCODE: opcode_r <= pwdata[15:0];
          `OFS_EXT_HI: ext_hi_r <= pwdata[15:0];
          `OFS_EXT_LO: ext_lo_r <= pwdata[15:0];
          `OFS_OPERAND: operand_r <= pwdata;
          `OFS_COUNT_REG: count_reg_r <= pwdata;
          `OFS_STACK_PTR: stack_ptr_r <= pwdata;
          `OFS_ADDR_REG_N: addr_reg_n_r <= pwdata;
          `OFS_CCR: ccr_r <= pwdata[4:0];
          `OFS_CTRL: begin
            if (pwdata[`CTRL_START_BIT]) begin
              state_r <= S_EXEC;
              done_r <= 1'b0;
              illegal_r <= 1'b0;
            end
          end
          default: ;
        endcase
      end
      case (state_r)
        S_IDLE: ;
        S_EXEC: begin
          state_r <= S_IDLE;
          done_r <= 1'b1;
          if (is_link_w || is_link_l) begin
            kind_r <= `KIND_LINK;
            state_r <= S_PUSH;
            done_r <= 1'b0;
          end else if ((is_shift_mem && mem_alt_ok) || is_shift_reg) begin
            kind_r <= is_shift_mem ? `KIND_SHIFT_MEM : `KIND_SHIFT_REG;
            result_r <= is_shift_mem ? sh_val : sh_merged;
            ccr_r[`CCR_V] <= 1'b0;
            ccr_r[`CCR_N] <= sh_neg;
            ccr_r[`CCR_Z] <= (sh_val == 32'h00000000);
            ccr_r[`CCR_C] <= (sh_count != 7'h00) & sh_last;
            if (sh_count != 7'h00) begin
              ccr_r[`CCR_X] <= sh_last;
            end
          end else if (is_move && dst_ok && src_ok) begin
            kind_r <= `KIND_MOVE;
            result_r <= mv_val;
            ccr_r[`CCR_N] <= mv_neg;
            ccr_r[`CCR_Z] <= (mv_val == 32'h00000000);
            ccr_r[`CCR_V] <= 1'b0;
            ccr_r[`CCR_C] <= 1'b0;
          end else begin
            kind_r <= `KIND_NONE;
            illegal_r <= 1'b1;
          end
        end
        S_PUSH: begin
          stack_ptr_r <= stack_ptr_r - `STACK_STEP;
          push_addr_r <= stack_ptr_r - `STACK_STEP;
          push_data_r <= addr_reg_n_r;
          state_r <= S_COPY;
        end
        S_COPY: begin
          addr_reg_n_r <= stack_ptr_r;
          result_r <= {29'h00000000, link_reg};
          state_r <= S_ADD;
        end
        S_ADD: begin
          stack_ptr_r <= stack_ptr_r + link_disp;
          done_r <= 1'b1;
          state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // APB answer, one wait state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel && penable && !pready && !pwrite) begin
        case (ofs)
          `OFS_OPCODE: prdata <= {16'h0000, opcode_r};
          `OFS_EXT_HI: prdata <= {16'h0000, ext_hi_r};
          `OFS_EXT_LO: prdata <= {16'h0000, ext_lo_r};
          `OFS_OPERAND: prdata <= operand_r;
          `OFS_COUNT_REG: prdata <= count_reg_r;
          `OFS_STACK_PTR: prdata <= stack_ptr_r;
          `OFS_ADDR_REG_N: prdata <= addr_reg_n_r;
          `OFS_CCR: prdata <= {27'h0000000, ccr_r};
          `OFS_STATUS: prdata <= status_word;
          `OFS_RESULT: prdata <= result_r;
          `OFS_PUSH_ADDR: prdata <= push_addr_r;
          `OFS_PUSH_DATA: prdata <= push_data_r;
          default: prdata <= 32'h00000000;
        endcase
      end else if (psel && penable && !pready) begin
        prdata <= 32'h00000000;
      end
    end
  end
endmodule // frame_shift_move_exec

/* File: test/frame_shift_move_exec_checker.sv */
// Bus protocol assertions for the execute block
`timescale 1ns/1ps
module frame_shift_move_exec_checker (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wait_one_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
  ready_access_a: assert property (pready |-> psel && penable) else $error("stray ready");
  err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
  err_high_a: assert property (pready && paddr[31:8] != 24'h0 |-> pslverr)
    else $error("high address accepted");
  err_align_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned accepted");
  mapped_ok_a: assert property (pready && paddr <= 32'h30 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped refused");
  err_rdata_a: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("unmapped data");
  write_rdata_a: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("write data");
  cover property (pready && pslverr);
  cover property (pready && pwrite);
  cover property (pready && !pwrite && prdata != 32'h0);
endmodule // frame_shift_move_exec_checker
bind frame_shift_move_exec frame_shift_move_exec_checker u_frame_shift_move_exec_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

/* File: test/frame_shift_move_exec_tb.sv */
// Self-checking bench for the execute block
`timescale 1ns/1ps
`include "frame_shift_move_defines.vh"
module frame_shift_move_exec_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [31:0] q;
  logic e;
  frame_shift_move_exec u_frame_shift_move_exec (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  initial begin
    forever #2 pclk = ~pclk;
  end
  task automatic tally_and_finish();
    $display("Counts: compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, {24'h0, a}, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, {24'h0, a}, 32'h0);
    chk(q, x);
  endtask
  task automatic run(input logic [15:0] op, input logic [31:0] v, input logic [4:0] c);
    int n;
    wr(`OFS_OPCODE, {16'h0, op});
    wr(`OFS_OPERAND, v);
    wr(`OFS_CCR, {27'h0, c});
    wr(`OFS_CTRL, 32'h1);
    n = 0;
    q = 32'h0;
    while (q[1:0] !== 2'b10 && n < 20) begin
      apb(1'b0, {24'h0, `OFS_STATUS}, 32'h0);
      n++;
    end
    chk({30'h0, q[1:0]}, 32'h2);
  endtask
  task automatic sc(input logic [15:0] op, input logic [31:0] v, input logic [4:0] c,
    input logic [31:0] r, input logic [4:0] f);
    run(op, v, c);
    rdc(`OFS_RESULT, r);
    rdc(`OFS_CCR, {27'h0, f});
  endtask
  task automatic ill(input logic [15:0] op);
    run(op, 32'h55, 5'h0A);
    chk({26'h0, q[5:0]}, 32'h6);
    rdc(`OFS_CCR, 32'hA);
  endtask
  task automatic t_bus();
    rdc(`OFS_CCR, 32'h0);
    rdc(`OFS_STATUS, 32'h0);
    wr(`OFS_RESULT, 32'h55);
    rdc(`OFS_RESULT, 32'h0);
    apb(1'b0, 32'h34, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 32'h0000011C, 32'h1F);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 32'h0000001E, 32'h1F);
    chk({31'h0, e}, 32'h1);
    rdc(`OFS_CCR, 32'h0);
    chk({31'h0, e}, 32'h0);
    $display("done: bus");
  endtask
  task automatic t_link();
    wr(`OFS_STACK_PTR, 32'h1000);
    wr(`OFS_ADDR_REG_N, 32'hAAAA5555);
    wr(`OFS_EXT_HI, 32'hFFF0);
    run(16'h4E53, 32'h0, 5'h1F);
    chk({26'h0, q[5:0]}, 32'h0A);
    rdc(`OFS_PUSH_ADDR, 32'hFFC);
    rdc(`OFS_PUSH_DATA, 32'hAAAA5555);
    rdc(`OFS_ADDR_REG_N, 32'hFFC);
    rdc(`OFS_STACK_PTR, 32'hFEC);
    rdc(`OFS_CCR, 32'h1F);
    rdc(`OFS_RESULT, 32'h3);
    wr(`OFS_EXT_HI, 32'h0001);
    wr(`OFS_EXT_LO, 32'h0000);
    run(16'h480F, 32'h0, 5'h0);
    chk({26'h0, q[5:0]}, 32'h0A);
    rdc(`OFS_STACK_PTR, 32'h10FE8);
    rdc(`OFS_RESULT, 32'h7);
    $display("done: link");
  endtask
  task automatic t_shift();
    sc(16'hE108, 32'h12345681, 5'h00, 32'h12345600, 5'h15);
    sc(16'hE248, 32'h00008001, 5'h00, 32'h00004000, 5'h11);
    sc(16'hEE88, 32'h000000C0, 5'h00, 32'h00000001, 5'h11);
    wr(`OFS_COUNT_REG, 32'h41);
    sc(16'hE3A8, 32'h80000001, 5'h00, 32'h00000002, 5'h11);
    wr(`OFS_COUNT_REG, 32'h40);
    sc(16'hE328, 32'h00000080, 5'h10, 32'h00000080, 5'h18);
    sc(16'hE2D0, 32'h00018003, 5'h00, 32'h00004001, 5'h11);
    sc(16'hE3D0, 32'h00008000, 5'h02, 32'h00000000, 5'h15);
    ill(16'hE2C0);
    ill(16'hE2FC);
    ill(16'hE2FA);
    $display("done: shift");
  endtask
  task automatic t_move();
    sc(16'h1000, 32'h12345680, 5'h1F, 32'h00000080, 5'h18);
    sc(16'h3000, 32'hFFFF0000, 5'h03, 32'h00000000, 5'h04);
    sc(16'h2000, 32'h80000000, 5'h00, 32'h80000000, 5'h08);
    sc(16'h2080, 32'h00000001, 5'h03, 32'h00000001, 5'h00);
    ill(16'h1008);
    ill(16'h2040);
    ill(16'h29C0);
    $display("done: move");
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_bus();
    t_link();
    t_shift();
    t_move();
    tally_and_finish();
  end
endmodule // frame_shift_move_exec_tb
